// ===== verilog/arp_map.svh
// Named constants shared by the result readout port files.
// Assumes it is included by bare name from files that need the values.
`ifndef ARP_MAP_SVH
`define ARP_MAP_SVH

// Level of the interface select pin that picks the parallel port.
`define ARP_SEL_PAR 1'h0
// Level of the interface select pin that picks the serial port.
`define ARP_SEL_SER 1'h1
// Result width in bits.
`define ARP_RES_W 32'h0000_0012
// Number of converted channels.
`define ARP_NCH 32'h0000_0008
// Width of the parallel data bus.
`define ARP_PBUS_W 32'h0000_0010
// Idle level of the active-low strobes after reset.
`define ARP_STROBE_IDLE 1'h1
// Idle level of plain active-high pins after reset.
`define ARP_PIN_IDLE 1'h0

`endif

// ===== verilog/arp_pkg.sv
// Types shared by the result readout port modules.
// Assumes nothing beyond a SystemVerilog compiler.
package arp_pkg;

  // Converter activity as seen by the readout port.
  typedef enum logic {
    ARP_IDLE,
    ARP_CONV
  } arp_cnv_t;

endpackage : arp_pkg

// ===== verilog/arp_lnk_if.sv
// Carrier for the event that leaves the serial clock domain.
// Assumes the source toggles on serial clock edges and the sink resamples.
`timescale 1ns/1ps

interface arp_lnk_if;
  // Flips once for every serial clock falling edge inside a frame.
  logic fall_tog;

  // Serial clock side drives the toggle.
  modport src (output fall_tog);
  // System clock side only reads it through a synchroniser.
  modport dst (input fall_tog);
endinterface : arp_lnk_if

// ===== verilog/arp_sync.sv
// Three-stage pin synchroniser with an agreement filter.
// Assumes the input is asynchronous to mclk; output is a clean level.
`timescale 1ns/1ps

module arp_sync #(
  parameter logic RST_VAL = 1'h0
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic pin,
  output logic lvl
);

  logic s1_r; // First stage, read only by the second stage.
  logic s2_r; // Second stage.
  logic s3_r; // Third stage.
  logic lvl_r; // Filtered level.

  // The level moves only once stages two and three agree, which rejects
  // a value caught while the first stage was still settling.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      lvl_r <= RST_VAL;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        lvl_r <= s3_r;
      end
    end
  end

  assign lvl = lvl_r;

endmodule : arp_sync

// ===== verilog/arp_sclk_edge.sv
// Serial clock domain front end: counts falling edges inside a frame.
// Assumes sclk may stop between frames; only edges while framed count.
`timescale 1ns/1ps

module arp_sclk_edge (
  input wire logic sclk,
  input wire logic nrst,
  input wire logic cs_n,
  arp_lnk_if.src lnk
);

  logic tog_r; // Flips on each framed falling edge.

  // The host samples on the falling edge, so that edge marks one bit as
  // consumed; the system clock side then moves the bit pointer on.
  always_ff @(negedge sclk or negedge nrst) begin
    if (!nrst) begin
      tog_r <= 1'h0;
    end else if (!cs_n) begin
      tog_r <= ~tog_r;
    end
  end

  assign lnk.fall_tog = tog_r;

endmodule : arp_sclk_edge

// ===== verilog/arp_readout.sv
// Result readout port of an eight-channel simultaneous sampling converter.
// Assumes the converter core pulses core_done on mclk when all channels
// are converted, with core_results valid in that cycle; sclk is the host
// serial clock and all other pins are asynchronous to mclk.
`timescale 1ns/1ps
`include "arp_map.svh"

module arp_readout #(
  parameter int RES_W = `ARP_RES_W,
  parameter int NCH = `ARP_NCH,
  parameter int PBUS_W = `ARP_PBUS_W
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic interface_select,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic convert_start,
  input wire logic core_done,
  input wire logic [RES_W-1:0] core_results [NCH],
  output logic busy,
  output logic [PBUS_W-1:0] parallel_data_bus,
  output logic parallel_data_bus_oe,
  output logic serial_out_a,
  output logic serial_out_a_oe,
  output logic serial_out_b,
  output logic serial_out_b_oe,
  output logic first_channel_flag,
  output logic first_channel_flag_oe
);
  import arp_pkg::*;

  // Channel index, word index and bit index widths.
  localparam int CH_W = $clog2(NCH);
  localparam int WI_W = CH_W + 1;
  localparam int BIT_W = $clog2(RES_W);
  // Bits left for the second parallel word of a channel.
  localparam int LO_W = RES_W - PBUS_W;
  // Offset from a channel on output A to the one on output B.
  localparam logic [CH_W-1:0] HALF = CH_W'(NCH / 2);
  localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(RES_W - 1);
  localparam logic [WI_W-1:0] LAST_WORD = WI_W'(2 * NCH - 1);

  logic sel_f; // Filtered interface select level.
  logic cs_f; // Filtered chip select, active low.
  logic rd_f; // Filtered read strobe, active low.
  logic cnv_f; // Filtered conversion start.
  logic tog_f; // Filtered serial edge toggle.
  logic cnv_d_r; // Conversion start from the previous cycle.
  logic tog_d_r; // Toggle value already acted on.
  logic strobe_d_r; // Parallel strobe from the previous cycle.
  arp_cnv_t state_r; // Converter activity.
  logic busy_r; // Busy pin register.
  logic [RES_W-1:0] res_r [NCH]; // Output result registers.
  logic [WI_W-1:0] widx_r; // Next parallel word to present.
  logic [PBUS_W-1:0] pdata_r; // Parallel bus value.
  logic par_oe_r; // Parallel bus enable.
  logic [BIT_W-1:0] bitc_r; // Serial bit pointer, zero is the MSB.
  logic [CH_W-1:0] chan_r; // Serial channel pointer on output A.
  logic ser_a_r; // Serial output A value.
  logic ser_b_r; // Serial output B value.
  logic ser_oe_r; // Serial output enable.
  logic flag_r; // First channel flag value.
  logic flag_oe_r; // First channel flag enable.
  logic cnv_rise; // Conversion start edge.
  logic load; // Results are taken this cycle.
  logic strobe; // Parallel read in progress.
  logic strobe_fall; // Start of a parallel read.
  logic sfall; // One serial bit consumed by the host.
  logic [BIT_W-1:0] bpos; // Result bit position on the serial lines.
  logic [CH_W-1:0] chan_b; // Channel currently on output B.

  // Carrier for the event leaving the serial clock domain.
  arp_lnk_if lnk ();

  // Serial clock domain edge counter.
  arp_sclk_edge u_sclk (
    .sclk(sclk),
    .nrst(nrst),
    .cs_n(cs_n),
    .lnk(lnk)
  );

  // Pin synchronisers; the strobes idle high so reset holds them there.
  arp_sync #(.RST_VAL(`ARP_PIN_IDLE)) u_sel (
    .mclk(mclk),
    .nrst(nrst),
    .pin(interface_select),
    .lvl(sel_f)
  );
  arp_sync #(.RST_VAL(`ARP_STROBE_IDLE)) u_cs (
    .mclk(mclk),
    .nrst(nrst),
    .pin(cs_n),
    .lvl(cs_f)
  );
  arp_sync #(.RST_VAL(`ARP_STROBE_IDLE)) u_rd (
    .mclk(mclk),
    .nrst(nrst),
    .pin(rd_n),
    .lvl(rd_f)
  );
  arp_sync #(.RST_VAL(`ARP_PIN_IDLE)) u_cnv (
    .mclk(mclk),
    .nrst(nrst),
    .pin(convert_start),
    .lvl(cnv_f)
  );
  // The toggle comes from another clock, so it is treated like a pin.
  arp_sync #(.RST_VAL(`ARP_PIN_IDLE)) u_tog (
    .mclk(mclk),
    .nrst(nrst),
    .pin(lnk.fall_tog),
    .lvl(tog_f)
  );

  // Edge and event decode on the filtered levels.
  assign cnv_rise = cnv_f && !cnv_d_r;
  assign load = core_done && (state_r == ARP_CONV);
  // Joined or separate strobes decode the same way.
  assign strobe = !cs_f && !rd_f && (sel_f == `ARP_SEL_PAR);
  assign strobe_fall = strobe && !strobe_d_r;
  assign sfall = (tog_f != tog_d_r) && (sel_f == `ARP_SEL_SER);
  assign bpos = LAST_BIT - bitc_r;
  // Output B runs half a sequence ahead of output A.
  assign chan_b = chan_r ^ HALF;

  // Edge history registers.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnv_d_r <= `ARP_PIN_IDLE;
      tog_d_r <= `ARP_PIN_IDLE;
      strobe_d_r <= 1'h0;
    end else begin
      cnv_d_r <= cnv_f;
      tog_d_r <= tog_f;
      strobe_d_r <= strobe;
    end
  end

  // Conversion tracking. A second start during a conversion is ignored,
  // since the core cannot restart before it finishes.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ARP_IDLE;
      busy_r <= 1'h0;
    end else begin
      case (state_r)
        ARP_IDLE: begin
          if (cnv_rise) begin
            state_r <= ARP_CONV;
            busy_r <= 1'h1;
          end
        end
        ARP_CONV: begin
          if (core_done) begin
            state_r <= ARP_IDLE;
            busy_r <= 1'h0;
          end
        end
        default: begin
          state_r <= ARP_IDLE;
          busy_r <= 1'h0;
        end
      endcase
    end
  end

  // Output result registers change only when busy falls, so reads made
  // during a conversion see the previous results untouched.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) begin
        res_r[i] <= '0;
      end
    end else if (load) begin
      for (int i = 0; i < NCH; i++) begin
        res_r[i] <= core_results[i];
      end
    end
  end

  // Parallel word pointer. A load in the same cycle as a strobe wins, so
  // the next read always starts from the first channel of new results.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      widx_r <= '0;
    end else if (load) begin
      widx_r <= '0;
    end else if (strobe_fall) begin
      // Wraps after the last low word of the last channel.
      widx_r <= (widx_r == LAST_WORD) ? '0 : widx_r + 1'h1;
    end
  end

  // Parallel data: even words carry the high bits, odd words the low
  // bits padded with zeros.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pdata_r <= '0;
    end else if (strobe_fall) begin
      if (!widx_r[0]) begin
        pdata_r <= res_r[widx_r[WI_W-1:1]][RES_W-1 -: PBUS_W];
      end else begin
        pdata_r <= {{(PBUS_W-LO_W){1'b0}},
                    res_r[widx_r[WI_W-1:1]][LO_W-1:0]};
      end
    end
  end

  // Parallel bus enable follows select and read; a rising select drops
  // it whatever the read strobe does.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      par_oe_r <= 1'h0;
    end else begin
      par_oe_r <= strobe;
    end
  end

  // Serial pointers advance once per consumed bit; after the last bit of
  // a channel the next channel starts at its MSB.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bitc_r <= '0;
      chan_r <= '0;
    end else if (load) begin
      bitc_r <= '0;
      chan_r <= '0;
    end else if (sfall) begin
      if (bitc_r == LAST_BIT) begin
        bitc_r <= '0;
        chan_r <= chan_r + 1'h1;
      end else begin
        bitc_r <= bitc_r + 1'h1;
      end
    end
  end

  // Serial data lines. The MSB is already waiting when a frame opens, and
  // each later bit appears a few mclk cycles after the host sampled the
  // previous one, well before the next falling edge.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ser_a_r <= 1'h0;
      ser_b_r <= 1'h0;
    end else begin
      ser_a_r <= res_r[chan_r][bpos];
      ser_b_r <= res_r[chan_b][bpos];
    end
  end

  // Serial enables and the first channel flag. The flag looks at the
  // channel on output A only.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ser_oe_r <= 1'h0;
      flag_oe_r <= 1'h0;
      flag_r <= 1'h0;
    end else begin
      ser_oe_r <= !cs_f && (sel_f == `ARP_SEL_SER);
      flag_oe_r <= !cs_f;
      flag_r <= !cs_f && (sel_f == `ARP_SEL_SER) && (chan_r == '0);
    end
  end

  assign busy = busy_r;
  assign parallel_data_bus = pdata_r;
  assign parallel_data_bus_oe = par_oe_r;
  assign serial_out_a = ser_a_r;
  assign serial_out_a_oe = ser_oe_r;
  assign serial_out_b = ser_b_r;
  assign serial_out_b_oe = ser_oe_r;
  assign first_channel_flag = flag_r;
  assign first_channel_flag_oe = flag_oe_r;

  // Checks on the port behaviour.
  par_mode_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    par_oe_r |-> $past(sel_f) == `ARP_SEL_PAR)
    else $error("parallel bus driven outside parallel mode");

  par_drive_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    (cs_f || rd_f) |=> !par_oe_r)
    else $error("parallel bus driven without select and read");

  cs_release_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    $rose(cs_f) |=> !par_oe_r && !ser_oe_r && !flag_oe_r)
    else $error("outputs still driven after select rose");

  word_split_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    (strobe_fall && !load && widx_r[0]) |=>
    pdata_r[PBUS_W-1:LO_W] == '0 && widx_r[0] == 1'b0)
    else $error("low word carries stray high bits");

  word_wrap_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    (strobe_fall && !load && widx_r == LAST_WORD) |=> widx_r == '0)
    else $error("parallel pointer did not wrap after last word");

  ser_mode_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    ser_oe_r |-> $past(sel_f) == `ARP_SEL_SER && !$past(cs_f))
    else $error("serial lines driven outside a serial frame");

  bit_wrap_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sfall && !load && bitc_r == LAST_BIT) |=>
    bitc_r == '0 && chan_r == $past(chan_r) + 1'h1)
    else $error("serial channel did not advance after last bit");

  flag_chan_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    flag_r |-> $past(chan_r) == '0 && flag_oe_r)
    else $error("first channel flag high off channel one on A");

  busy_rise_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    (state_r == ARP_IDLE && cnv_rise) |=> busy_r ##0 state_r == ARP_CONV)
    else $error("busy did not rise on conversion start");

  load_reset_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    load |=> widx_r == '0 && bitc_r == '0 && chan_r == '0 && !busy_r)
    else $error("pointers not reset when results loaded");

  read_busy_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    (strobe_fall && busy_r && !load && widx_r != LAST_WORD) |=>
    widx_r == $past(widx_r) + 1'h1)
    else $error("parallel read refused during conversion");

endmodule : arp_readout

// ===== verification/arp_host.sv
// Host model for the readout port: chip select, read strobe, serial clock.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/1ps

module arp_host (
  output logic sclk,
  output logic cs_n,
  output logic rd_n,
  input wire logic [15:0] pbus,
  input wire logic pbus_oe,
  input wire logic ser_a,
  input wire logic ser_b,
  input wire logic flag,
  input wire logic ser_a_oe,
  input wire logic ser_b_oe,
  input wire logic flag_oe
);
  // Levels seen at each serial clock falling edge, oldest first.
  logic qa [$];
  logic qb [$];
  logic qf [$];

  // Idle state: deselected, strobe high, serial clock parked low.
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    rd_n = 1'h1;
  end

  // One parallel word; joined moves chip select together with the strobe.
  // Each phase lasts 40 ns because the port synchronises its pins.
  task pread(input bit joined, output logic [15:0] d, output logic oe,
             output logic off);
    rd_n = 1'h0;
    if (joined) cs_n = 1'h0;
    #40;
    // A released bus has no pull, so the model sees the stale value
    // inverted; a missing enable then shows up as a wrong word.
    d = pbus_oe ? pbus : ~pbus;
    oe = pbus_oe;
    rd_n = 1'h1;
    if (joined) cs_n = 1'h1;
    #40;
    off = pbus_oe;
  endtask : pread

  // One frame of n serial clocks at 125 ns; the clock stands still outside.
  // The small start offset keeps it out of phase with the system clock.
  task sframe(input int n);
    #1.3;
    cs_n = 1'h0;
    repeat (n) begin
      #62.5 sclk = 1'h1;
      #62.5;
      // Undriven lines read back inverted, as for the parallel bus.
      qa.push_back(ser_a_oe ? ser_a : ~ser_a);
      qb.push_back(ser_b_oe ? ser_b : ~ser_b);
      qf.push_back(flag_oe ? flag : ~flag);
      sclk = 1'h0;
    end
    #30 cs_n = 1'h1;
    #60;
  endtask : sframe

  // Parks chip select at a level, for reads with it tied low.
  task cs_level(input logic v);
    cs_n = v;
  endtask : cs_level
endmodule : arp_host

// ===== verification/testbench.sv
// Self-checking bench for the result readout port.
// Assumes the host model drives the pins and this bench models the core.
`timescale 1ns/1ps

module testbench;
  logic mclk;
  logic nrst;
  logic sel;
  logic conv;
  logic done;
  logic [17:0] nres [8]; // Results offered by the core model.
  logic [17:0] cur [8]; // Results the port should present now.
  logic busy, poe, sa, sa_oe, sb, sb_oe, fl, fl_oe;
  logic [15:0] pbus;
  logic sclk, cs_n, rd_n;
  int fails = 0;
  int checks_done = 0;
  integer seed = 32'h2747_ff70;

  arp_readout dut_u (
    .mclk(mclk), .nrst(nrst), .sclk(sclk), .interface_select(sel),
    .cs_n(cs_n), .rd_n(rd_n), .convert_start(conv), .core_done(done),
    .core_results(nres), .busy(busy), .parallel_data_bus(pbus),
    .parallel_data_bus_oe(poe), .serial_out_a(sa),
    .serial_out_a_oe(sa_oe), .serial_out_b(sb), .serial_out_b_oe(sb_oe),
    .first_channel_flag(fl), .first_channel_flag_oe(fl_oe)
  );

  arp_host host_u (
    .sclk(sclk), .cs_n(cs_n), .rd_n(rd_n), .pbus(pbus), .pbus_oe(poe),
    .ser_a(sa), .ser_b(sb), .flag(fl), .ser_a_oe(sa_oe),
    .ser_b_oe(sb_oe), .flag_oe(fl_oe)
  );

  // System clock at 200 MHz.
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  // Single-bit and word comparisons; case inequality keeps X from passing.
  task chk1(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk1

  task chk16(input logic [15:0] got, input logic [15:0] exp,
             input string msg);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk16

  // Verdict and end of run, shared by the main sequence and the watchdog.
  task test_done;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // Word k of a parallel read: even words high bits, odd words low two.
  function automatic logic [15:0] pword(input int k);
    logic [17:0] r;
    r = cur[(k / 2) % 8];
    return (k % 2 == 0) ? r[17:2] : {14'h0, r[1:0]};
  endfunction : pword

  // Starts a conversion and waits, bounded, for busy to rise.
  task conv_start;
    int n;
    @(negedge mclk) conv = 1'h1;
    n = 0;
    while (busy !== 1'h1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk1(busy, 1'h1, "busy did not rise");
    conv = 1'h0;
  endtask : conv_start

  // Ends a conversion with fresh results; rnd picks random or a pattern.
  task conv_end(input bit rnd);
    for (int i = 0; i < 8; i++) begin
      nres[i] = rnd ? 18'($random(seed)) : 18'h2_aaaa ^ 18'(i);
    end
    @(negedge mclk) done = 1'h1;
    @(negedge mclk) done = 1'h0;
    @(negedge mclk);
    chk1(busy, 1'h0, "busy did not fall");
    cur = nres;
  endtask : conv_end

  // Reads n parallel words starting at word k0 and checks bus enables.
  task pcheck(input bit joined, input int k0, input int n);
    logic [15:0] d;
    logic oe, off;
    for (int k = k0; k < k0 + n; k++) begin
      host_u.pread(joined, d, oe, off);
      chk16(d, pword(k), "parallel word");
      chk1(oe, 1'h1, "bus not driven");
      chk1(off, 1'h0, "bus not released");
    end
  endtask : pcheck

  // Serial read of frames of n clocks; output B runs four channels ahead.
  task scheck(input int frames, input int n);
    int ch;
    host_u.qa.delete();
    host_u.qb.delete();
    host_u.qf.delete();
    repeat (frames) host_u.sframe(n);
    for (int j = 0; j < frames * n; j++) begin
      ch = j / 18;
      chk1(host_u.qa[j], cur[ch % 8][17 - j % 18], "a bit");
      chk1(host_u.qb[j], cur[(ch + 4) % 8][17 - j % 18], "b bit");
      chk1(host_u.qf[j], ch == 0, "flag level");
    end
    chk1(sa_oe, 1'h0, "serial not released");
    chk1(sb_oe, 1'h0, "serial b not released");
    chk1(fl_oe, 1'h0, "flag not released");
  endtask : scheck

  // Main sequence: parallel reads first, then serial reads.
  initial begin
    logic [15:0] d;
    logic oe, off;
    sel = 1'h0;
    conv = 1'h0;
    done = 1'h0;
    nrst = 1'h0;
    for (int i = 0; i < 8; i++) nres[i] = 18'h0_0000;
    repeat (3) @(negedge mclk);
    nrst = 1'h1;
    repeat (8) @(negedge mclk);
    chk1(poe, 1'h0, "bus driven while idle");
    conv_start;
    conv_end(1'h0);
    host_u.cs_level(1'h0);
    // A partial read leaves the pointer mid-way; the load must reset it.
    pcheck(1'h0, 0, 3);
    conv_start;
    pcheck(1'h0, 3, 2);
    conv_end(1'h1);
    pcheck(1'h0, 0, 16);
    host_u.cs_level(1'h1);
    #100;
    pcheck(1'h1, 16, 16);
    @(negedge mclk) sel = 1'h1;
    repeat (10) @(negedge mclk);
    conv_start;
    conv_end(1'h1);
    conv_start;
    scheck(1, 72);
    conv_end(1'h1);
    host_u.pread(1'h1, d, oe, off);
    chk1(oe, 1'h0, "parallel bus driven in serial mode");
    scheck(8, 18);
    test_done;
  end

  // Watchdog: the whole sequence needs well under 100 us.
  initial begin
    #300000;
    fails++;
    test_done;
  end
endmodule : testbench
